// ==== ssadc_pkg.sv ====
package ssadc_pkg;
  // Register offsets
  localparam logic [7:0] ANALOG_CONTROL_ADDR        = 8'h1D;
  localparam logic [7:0] ANALOG_CHANNEL_SELECT_ADDR = 8'h1C;
  localparam logic [7:0] CMP_STATUS_ADDR            = 8'h1E;
  // Analog control bit positions
  localparam int CHARGE_DRIVE_BIT       = 0;
  localparam int CONV_MODE_LO_BIT       = 1;
  localparam int CONV_MODE_HI_BIT       = 2;
  localparam int CAPTURE_FROM_CMP_BIT   = 3;
  localparam int COMPARATOR2_POWER_BIT  = 5;
  localparam int COMPARATOR1_POWER_BIT  = 6;
  localparam int RAMP_SOURCE_ENABLE_BIT = 7;
  // Channel select bit positions
  localparam int PIN_SELECT_LSB  = 0;
  localparam int REF_SELECT_BIT  = 7;
  // Status register bit positions
  localparam int CMP2_RISE_FLAG_BIT  = 0;
  localparam int CMP2_FLAG_CLEAR_BIT = 1;
  // Reset values
  localparam logic [7:0] ANALOG_CONTROL_RESET        = 8'h00;
  localparam logic [7:0] ANALOG_CHANNEL_SELECT_RESET = 8'h00;
  // Conversion modes
  typedef enum logic [1:0] {
    SSADC_MODE_MANUAL = 2'h0,
    SSADC_MODE_AUTO_DIS = 2'h1,
    SSADC_MODE_TOF_ICF = 2'h2,
    SSADC_MODE_OCF_ICF = 2'h3
  } ssadc_mode_type;
endpackage

// ==== ssadc_edge_flag.sv ====
`timescale 1ns/100ps
// Sticky rising-edge flag; set wins over a same-cycle clear
module ssadc_edge_flag (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic level,
  input  wire logic clear,
  output logic      flag,
  output logic      rise
);
  logic level_q;
  assign rise = level & ~level_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      level_q <= 1'b0;
      flag    <= 1'b0;
    end else begin
      level_q <= level;
      flag    <= rise | (flag & ~clear);
    end
  end
endmodule

// ==== ssadc_control.sv ====
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
// Function
// - Reference switch only when no pin selected
// - Each pin select drives its own switch
// - Ground switch when nothing selected
// - Enable bits clear power down analog
// - Reset clears analog control register
// - Charge set with source enable sources
// - Charge clear with source enable sinks
// - Mode bits inert without source enable, except capture routing
// - Reset returns to manual mode
// - Source disabled: no source, no sink
// - Mode 0: only writes change charge
// - Mode 1: comparator 2 rise clears charge
// - Mode 2: overflow sets, capture clears
// - Mode 3: compare sets, capture clears
// - High mode bit set enables capture routing
// - Comparator 2 flag sticky on rise
// - Reset clears all pin selects
module ssadc_control (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       cmp2_out,
  input  wire logic       timer_overflow_flag,
  input  wire logic       output_compare_flag,
  input  wire logic       input_capture_flag,
  output logic            ref_switch,
  output logic      [3:0] pin_switch,
  output logic            ground_switch,
  output logic            ramp_source_power,
  output logic            comparator1_power,
  output logic            comparator2_power,
  output logic            ramp_sourcing,
  output logic            ramp_sinking,
  output logic            capture_from_cmp,
  output logic            cmp2_rise_flag
);
  logic [7:0] analog_control;
  logic [7:0] analog_channel_select;
  logic [7:0] next_rdata;
  logic       cmp2_rise;
  logic       cmp2_clear;
  logic       ovf_q;
  logic       ocf_q;
  logic       icf_q;

  wire wr_ctl = wr && (addr == ssadc_pkg::ANALOG_CONTROL_ADDR);
  wire wr_sel = wr && (addr == ssadc_pkg::ANALOG_CHANNEL_SELECT_ADDR);
  wire wr_sts = wr && (addr == ssadc_pkg::CMP_STATUS_ADDR);
  assign cmp2_clear = wr_sts && wdata[ssadc_pkg::CMP2_FLAG_CLEAR_BIT];

  // Timer flags are levels; only their rising edge is an event
  wire ovf_evt = timer_overflow_flag & ~ovf_q;
  wire ocf_evt = output_compare_flag & ~ocf_q;
  wire icf_evt = input_capture_flag & ~icf_q;

  wire src_en = analog_control[ssadc_pkg::RAMP_SOURCE_ENABLE_BIT];
  wire charge_drive    = analog_control[ssadc_pkg::CHARGE_DRIVE_BIT];
  wire [1:0] mode_bits = {analog_control[ssadc_pkg::CONV_MODE_HI_BIT],
                          analog_control[ssadc_pkg::CONV_MODE_LO_BIT]};
  ssadc_pkg::ssadc_mode_type mode;
  assign mode = ssadc_pkg::ssadc_mode_type'(mode_bits);

  ssadc_edge_flag u_cmp2_flag (
    .clk   (clk),
    .srst  (srst),
    .level (cmp2_out),
    .clear (cmp2_clear),
    .flag  (cmp2_rise_flag),
    .rise  (cmp2_rise)
  );

  // Hardware set/clear of the charge bit, gated by source enable
  logic hw_set;
  logic hw_clr;
  always_comb begin
    hw_set = 1'b0;
    hw_clr = 1'b0;
    if (src_en) begin
      unique case (mode)
        ssadc_pkg::SSADC_MODE_MANUAL: begin
          hw_set = 1'b0;
        end
        ssadc_pkg::SSADC_MODE_AUTO_DIS: begin
          hw_clr = cmp2_rise;
        end
        ssadc_pkg::SSADC_MODE_TOF_ICF: begin
          hw_set = ~charge_drive & ovf_evt;
          hw_clr = charge_drive & icf_evt;
        end
        ssadc_pkg::SSADC_MODE_OCF_ICF: begin
          hw_set = ~charge_drive & ocf_evt;
          hw_clr = charge_drive & icf_evt;
        end
      endcase
    end
  end

  // Write data with the charge bit resolved; hardware events win
  logic [7:0] ctl_wval;
  logic [7:0] next_ctl;
  always_comb begin
    ctl_wval = wr_ctl ? wdata : analog_control;
    if (wr_ctl && wdata[ssadc_pkg::CONV_MODE_HI_BIT])
      ctl_wval[ssadc_pkg::CAPTURE_FROM_CMP_BIT] = 1'b1;
    next_ctl = ctl_wval;
    if (hw_set)
      next_ctl[ssadc_pkg::CHARGE_DRIVE_BIT] = 1'b1;
    else if (hw_clr)
      next_ctl[ssadc_pkg::CHARGE_DRIVE_BIT] = 1'b0;
  end

  always_comb begin
    unique case (addr)
      ssadc_pkg::ANALOG_CONTROL_ADDR:        next_rdata = analog_control;
      ssadc_pkg::ANALOG_CHANNEL_SELECT_ADDR: next_rdata = analog_channel_select;
      ssadc_pkg::CMP_STATUS_ADDR:
        next_rdata = {7'h00, cmp2_rise_flag};
      default:                               next_rdata = 8'h00;
    endcase
  end

  // Switch decode: reference only with every pin select off
  wire [3:0] pins    = analog_channel_select[ssadc_pkg::PIN_SELECT_LSB +: 4];
  wire       ref_bit = analog_channel_select[ssadc_pkg::REF_SELECT_BIT];
  wire next_ref_sw = ref_bit && (pins == 4'h0);
  wire next_gnd_sw = !ref_bit && (pins == 4'h0);

  always_ff @(posedge clk) begin
    if (srst) begin
      analog_control        <= ssadc_pkg::ANALOG_CONTROL_RESET;
      analog_channel_select <= ssadc_pkg::ANALOG_CHANNEL_SELECT_RESET;
      ovf_q                 <= 1'b0;
      ocf_q                 <= 1'b0;
      icf_q                 <= 1'b0;
      rdata                 <= 8'h00;
    end else begin
      analog_control <= next_ctl;
      if (wr_sel)
        analog_channel_select <= wdata;
      ovf_q <= timer_overflow_flag;
      ocf_q <= output_compare_flag;
      icf_q <= input_capture_flag;
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  // Outputs registered, one cycle after the register they follow
  always_ff @(posedge clk) begin
    if (srst) begin
      ref_switch        <= 1'b0;
      pin_switch        <= 4'h0;
      ground_switch     <= 1'b1;
      ramp_source_power <= 1'b0;
      comparator1_power <= 1'b0;
      comparator2_power <= 1'b0;
      ramp_sourcing     <= 1'b0;
      ramp_sinking      <= 1'b0;
      capture_from_cmp  <= 1'b0;
    end else begin
      ref_switch        <= next_ref_sw;
      pin_switch        <= pins;
      ground_switch     <= next_gnd_sw;
      ramp_source_power <= src_en;
      comparator1_power <= analog_control[ssadc_pkg::COMPARATOR1_POWER_BIT];
      comparator2_power <= analog_control[ssadc_pkg::COMPARATOR2_POWER_BIT];
      ramp_sourcing     <= src_en & charge_drive;
      ramp_sinking      <= src_en & ~charge_drive;
      capture_from_cmp  <= analog_control[ssadc_pkg::CAPTURE_FROM_CMP_BIT];
    end
  end
endmodule

// ==== ssadc_control_assertions.sv ====
`timescale 1ns/100ps
module ssadc_control_assertions (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       cmp2_out,
  input wire logic       ref_switch,
  input wire logic [3:0] pin_switch,
  input wire logic       ground_switch,
  input wire logic       ramp_source_power,
  input wire logic       ramp_sourcing,
  input wire logic       ramp_sinking,
  input wire logic       capture_from_cmp,
  input wire logic       cmp2_rise_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  AST_REF: assert property (ref_switch |-> pin_switch == 4'h0)
    else $error("reference switch with a pin on");
  AST_GND: assert property (ground_switch == (!ref_switch && pin_switch == 4'h0))
    else $error("ground switch wrong");
  AST_OFF: assert property (!ramp_source_power |-> !ramp_sourcing && !ramp_sinking)
    else $error("ramp current while unpowered");
  AST_DIR: assert property (ramp_source_power |-> ramp_sourcing != ramp_sinking)
    else $error("ramp direction wrong");
  AST_RST: assert property ($fell(srst) |-> ground_switch && !ramp_source_power)
    else $error("state after reset wrong");
  AST_CAP: assert property (wr && addr == 8'h1D && wdata[2] |-> ##[1:2] capture_from_cmp)
    else $error("capture routing not set");
  AST_RISE: assert property ($rose(cmp2_out) |=> cmp2_rise_flag)
    else $error("rise flag not set");
  AST_HOLD: assert property (cmp2_rise_flag && !(wr && addr == 8'h1E) |=> cmp2_rise_flag)
    else $error("rise flag lost");
endmodule
bind ssadc_control ssadc_control_assertions ssadc_control_assertions_i (.clk, .srst, .addr,
  .wdata, .wr, .cmp2_out, .ref_switch, .pin_switch, .ground_switch, .ramp_source_power,
  .ramp_sourcing, .ramp_sinking, .capture_from_cmp, .cmp2_rise_flag);

// ==== ssadc_far_side.sv ====
`timescale 1ns/100ps
// Timer flags and comparator 2; a flag is held two cycles so each rise is one event
module ssadc_far_side (
  input wire logic       clk,
  output logic     [3:0] ev
);
  initial ev = 4'h0;
  task fire(input int n);
    @(posedge clk) ev[n] <= 1'h1;
    repeat (2) @(posedge clk);
    ev[n] <= 1'h0;
  endtask
endmodule

// ==== ssadc_control_bench.sv ====
`timescale 1ns/100ps
module ssadc_control_bench;
  logic       clk, srst, wr, rd, ref_switch, ground_switch, ramp_source_power;
  logic       comparator1_power, comparator2_power, ramp_sourcing, ramp_sinking;
  logic       capture_from_cmp, cmp2_rise_flag;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] pin_switch, ev;
  int         fail_count = 0, samples_checked = 0, cycles = 0;
  wire  [7:0] ana = {ref_switch, pin_switch, ground_switch, ramp_sourcing, ramp_sinking};
  wire  [7:0] pw  = {ramp_source_power, comparator1_power, comparator2_power, 1'h0,
                     capture_from_cmp, 2'h0, cmp2_rise_flag};
  ssadc_control ssadc_control_i (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata,
    .cmp2_out(ev[3]), .timer_overflow_flag(ev[0]), .output_compare_flag(ev[1]),
    .input_capture_flag(ev[2]), .ref_switch, .pin_switch, .ground_switch,
    .ramp_source_power, .comparator1_power, .comparator2_power, .ramp_sourcing,
    .ramp_sinking, .capture_from_cmp, .cmp2_rise_flag);
  ssadc_far_side ssadc_far_side_i (.clk, .ev);
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Waits until the derived outputs have followed the write
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'h1};
    @(posedge clk) wr <= 1'h0;
    repeat (2) @(negedge clk);
  endtask
  task rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) {addr, rd} <= {a, 1'h1};
    @(posedge clk) rd <= 1'h0;
    @(negedge clk) chk("rdata", rdata, exp);
  endtask
  task fire(input int n);
    ssadc_far_side_i.fire(n);
    repeat (3) @(negedge clk);
  endtask
  task tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {srst, wr, rd, addr, wdata} = {1'h1, 1'h0, 1'h0, 8'h00, 8'h00};
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    @(negedge clk) chk("chan", ana, 8'h04);
    chk("pwr", pw, 8'h00);
    rd_reg(8'h1D, 8'h00);
    rd_reg(8'h1F, 8'h00);
    for (int i = 0; i < 32; i++) begin
      wr_reg(8'h1C, {i[4], 3'h0, i[3:0]});
      chk("chan", ana, {i[4] && i[3:0] == 0, i[3:0], i[4:0] == 0, 2'h0});
    end
    wr_reg(8'h1C, 8'h00);
    wr_reg(8'h1D, 8'h06);
    fire(1);
    rd_reg(8'h1D, 8'h0E);
    chk("ramp", ana, 8'h04);
    wr_reg(8'h1D, 8'hE1);
    chk("pwr", pw, 8'hE0);
    for (int n = 0; n < 4; n++) fire(n);
    chk("ramp", ana, 8'h06);
    wr_reg(8'h1D, 8'hE0);
    chk("ramp", ana, 8'h05);
    wr_reg(8'h1E, 8'h02);
    wr_reg(8'h1D, 8'h83);
    chk("ramp", ana, 8'h06);
    fire(3);
    chk("ramp", ana, 8'h05);
    rd_reg(8'h1E, 8'h01);
    wr_reg(8'h1E, 8'h02);
    rd_reg(8'h1E, 8'h00);
    for (int m = 2; m < 4; m++) begin
      wr_reg(8'h1D, {5'h10, m[1:0], 1'h0});
      fire(m == 2 ? 1 : 0);
      chk("ramp", ana, 8'h05);
      fire(m == 2 ? 0 : 1);
      chk("ramp", ana, 8'h06);
      fire(2);
      chk("ramp", ana, 8'h05);
      rd_reg(8'h1D, {5'h11, m[1:0], 1'h0});
    end
    // Write of charge 0 lands in the same cycle as a compare event
    fork
      wr_reg(8'h1D, 8'h86);
      ssadc_far_side_i.fire(1);
    join
    chk("ramp", ana, 8'h06);
    rd_reg(8'h1D, 8'h8F);
    tally_and_finish();
  end
endmodule
